/* File: ext_bus_pkg.sv */
// types and constants for the external memory bus port logic
// assumes a single 40 MHz clock and a core that issues one request at a time
`default_nettype none
package ext_bus_pkg;

  localparam int          CLK_HZ          = 40_000_000;
  localparam logic [7:0]  LATCH_RESET     = 8'hFF;
  localparam logic [7:0]  LOW_LATCH_BUS   = 8'hFF;
  localparam int          WAIT_W          = 2;
  localparam int          ALE_CYCLES      = 1;
  localparam int          ADDR_CYCLES     = 1;
  localparam int          STROBE_CYCLES   = 1;

  // address width of one transfer
  typedef enum logic [1:0] {
    AW_8  = 2'b00,
    AW_16 = 2'b01,
    AW_17 = 2'b10
  } addr_width_t;

  // read strobe choice for data reads
  typedef enum logic [1:0] {
    RS_DATA  = 2'b00,
    RS_PROG  = 2'b01,
    RS_DATA2 = 2'b10,
    RS_PROG2 = 2'b11
  } strobe_cfg_t;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'b00,
    KIND_READ  = 2'b01,
    KIND_WRITE = 2'b10
  } bus_kind_t;

  typedef enum logic [1:0] {
    FORM_BYTE_REG = 2'b00,
    FORM_WORD     = 2'b01,
    FORM_DWORD    = 2'b10
  } insn_form_t;

  typedef struct packed {
    bus_kind_t   kind;
    insn_form_t  form;
    logic        ext_mode;
    logic [16:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } port_drive_t;

  // which width a transfer presents
  function automatic addr_width_t width_of(input bus_req_t r);
    if (r.kind == KIND_FETCH)
      return r.ext_mode ? AW_17 : AW_16;
    case (r.form)
      FORM_BYTE_REG: return AW_8;
      FORM_WORD:     return AW_16;
      FORM_DWORD:    return AW_17;
      default:       return AW_16;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: ext_bus_port.sv */
// external memory bus built on the low and high 8-bit ports
// assumes the core holds req stable while req_valid is high until req_done
`default_nettype none
module ext_bus_port
  import ext_bus_pkg::*;
#(
  parameter int W = WAIT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // configuration
  input  wire logic         page_mode,
  input  wire strobe_cfg_t  strobe_config_field,
  input  wire logic [W-1:0] wait_states,
  // software latch writes
  input  wire logic         low_latch_we,
  input  wire logic         high_latch_we,
  input  wire logic [7:0]   latch_wdata,
  output logic [7:0]        low_port_latch,
  output logic [7:0]        high_port_latch,
  // core request
  input  wire logic         req_valid,
  input  wire bus_req_t     req,
  output logic              req_done,
  output logic [7:0]        rdata,
  // pins
  input  wire logic [7:0]   low_port_in,
  input  wire logic [7:0]   high_port_in,
  output port_drive_t       low_port,
  output port_drive_t       high_port,
  output logic              addr_latch_strobe,
  output logic              program_read_strobe_b,
  output logic              data_read_strobe_b,
  output logic              write_strobe_b,
  output logic              addr16_out,
  output logic              addr16_oe
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ALE    = 2'b01,
    ST_ADDR   = 2'b10,
    ST_STROBE = 2'b11
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // one multiplexed port: address first, then write data or released for reads
  // a function so page and nonpage modes cannot drift apart
  function automatic port_drive_t mux_drive(input logic [7:0] addr_byte,
                                            input logic [7:0] data_byte,
                                            input logic       data_phase,
                                            input logic       writing);
    port_drive_t d;
    d.out = data_phase ? data_byte : addr_byte;
    d.oe  = (data_phase && !writing) ? 8'h00 : 8'hFF;
    return d;
  endfunction

  state_t      state;
  state_t      next_state;
  bus_req_t    cur;
  addr_width_t width;
  port_drive_t next_low;
  port_drive_t next_high;
  logic        phase_done;
  logic        start_strobe;
  logic        next_prog_b;
  logic        next_data_b;
  logic        next_wr_b;
  logic        next_ale;

  ////////////////////////////////////////////////////////////////////////////
  // idle pins look ahead to the request being taken, so the address is
  // already on the ports while the latch strobe is high
  wire bus_req_t   src        = (state == ST_IDLE) ? req : cur;
  wire logic       take       = (state == ST_IDLE) && req_valid;
  wire logic       next_bus   = next_state != ST_IDLE;
  wire logic       data_next  = next_state == ST_STROBE;
  wire logic       is_fetch   = cur.kind == KIND_FETCH;
  wire logic       is_write   = cur.kind == KIND_WRITE;
  wire logic       use_prog   = is_fetch || (cur.kind == KIND_READ &&
                                 strobe_config_field[0]);
  wire logic       in_bus     = state != ST_IDLE;
  wire logic       in_strobe  = state == ST_STROBE;
  wire logic       strobe_end = in_strobe && phase_done;
  wire logic [7:0] data_pins  = page_mode ? high_port_in : low_port_in;
  wire logic [7:0] hi_addr    = (width == AW_8) ? high_port_latch : src.addr[15:8];
  wire logic [7:0] lo_addr    = src.addr[7:0];
  // the stretch counter times only the strobe phase; address phases are fixed
  assign width        = width_of(src);
  assign start_strobe = state == ST_ADDR;

  wait_stretch #(
    .W (W)
  ) u_stretch (
    .clk   (clk),
    .rst_b (rst_b),
    .start (start_strobe),
    .waits (wait_states),
    .base  (2'(STROBE_CYCLES)),
    .done  (phase_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state and pin values
  // a request is taken only from idle; req_valid is a level, not a pulse
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = req_valid ? ST_ALE : ST_IDLE;
      ST_ALE:    next_state = ST_ADDR;
      ST_ADDR:   next_state = ST_STROBE;
      ST_STROBE: next_state = phase_done ? ST_IDLE : ST_STROBE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_comb begin
    // idle: pins follow the latches, low port open drain style
    next_low.out  = low_port_latch;
    next_low.oe   = ~low_port_latch;
    next_high.out = high_port_latch;
    next_high.oe  = 8'hFF;
    if (next_bus) begin
      if (!page_mode) begin
        next_high.out = hi_addr;
        next_high.oe  = 8'hFF;
        next_low      = mux_drive(lo_addr, cur.wdata, data_next, is_write);
      end else begin
        next_low.out  = lo_addr;
        next_low.oe   = 8'hFF;
        next_high     = mux_drive(hi_addr, cur.wdata, data_next, is_write);
      end
    end
    // latch strobe high only in the first cycle; address then held past its fall
    next_ale    = next_state == ST_ALE;
    next_wr_b   = !(next_state == ST_STROBE && is_write);
    next_prog_b = !(next_state == ST_STROBE && !is_write && use_prog);
    next_data_b = !(next_state == ST_STROBE && !is_write && !use_prog);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cur   <= '0;
    end else begin
      state <= next_state;
      if (take)
        cur <= req;
    end
  end

  // latches: bus cycles force the low latch high, high latch untouched
  // a low latch software write inside a bus cycle is lost: the bus owns the low latch
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_port_latch  <= LATCH_RESET;
      high_port_latch <= LATCH_RESET;
    end else begin
      if (in_bus)
        low_port_latch <= LOW_LATCH_BUS;
      else if (low_latch_we)
        low_port_latch <= latch_wdata;
      if (high_latch_we)
        high_port_latch <= latch_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins straight from flip-flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      low_port.out          <= LATCH_RESET;
      low_port.oe           <= 8'h00;
      high_port.out         <= LATCH_RESET;
      high_port.oe          <= 8'hFF;
      addr_latch_strobe     <= 1'b0;
      program_read_strobe_b <= 1'b1;
      data_read_strobe_b    <= 1'b1;
      write_strobe_b        <= 1'b1;
      addr16_out            <= 1'b0;
      addr16_oe             <= 1'b0;
      req_done              <= 1'b0;
      rdata                 <= 8'h00;
    end else begin
      low_port              <= next_low;
      high_port             <= next_high;
      addr_latch_strobe     <= next_ale;
      program_read_strobe_b <= next_prog_b;
      data_read_strobe_b    <= next_data_b;
      write_strobe_b        <= next_wr_b;
      // 17th bit only for wide transfers
      addr16_oe             <= next_bus && (width == AW_17);
      addr16_out            <= next_bus && src.addr[16];
      req_done              <= strobe_end;
      // sample in the last strobe cycle: memory has driven by then, and the
      // strobe only rises at this edge, so a late part is still covered
      if (strobe_end && !is_write)
        rdata <= data_pins;
    end
  end

endmodule
`default_nettype wire

/* File: ext_bus_sva.sv */
// checker for the external bus port: pin timing and port ownership
// assumes it is bound to ext_bus_port and sees only that module's ports
`default_nettype none
module ext_bus_sva
  import ext_bus_pkg::*;
#(
  parameter int W = WAIT_W
) (
  // clock, reset, configuration and high latch write enable
  input wire logic         clk, rst_b, page_mode, high_latch_we,
  input wire strobe_cfg_t  strobe_config_field,
  input wire logic [W-1:0] wait_states,
  // latches and core request
  input wire logic [7:0]   low_port_latch, high_port_latch,
  input wire bus_req_t     req,
  // pins
  input wire port_drive_t  low_port, high_port,
  input wire logic         addr_latch_strobe, program_read_strobe_b, data_read_strobe_b,
  input wire logic         write_strobe_b, addr16_out, addr16_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic       rd_low  = !(program_read_strobe_b && data_read_strobe_b);
  wire logic       any_low = rd_low || !write_strobe_b;
  wire logic       ale     = addr_latch_strobe;
  wire logic       fetch   = req.kind == KIND_FETCH;
  wire logic [7:0] data_oe = page_mode ? high_port.oe : low_port.oe;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start_w3;
    $rose(any_low) ##0 (&wait_states);
  endsequence
  sequence s_held4;
    any_low [*4] ##1 !any_low;
  endsequence
  a_addr_on_ports: assert property (ale && fetch |-> low_port.out == req.addr[7:0]
    && high_port.out == req.addr[15:8]) else $error("address missing on ports");
  a_addr_bit17: assert property (ale && fetch && req.ext_mode |-> addr16_oe
    && addr16_out == req.addr[16]) else $error("17th address bit wrong");
  a_addr_held: assert property ($fell(ale) |-> $stable(low_port) && $stable(high_port))
    else $error("address moved as latch strobe fell");
  a_low_forced: assert property (ale |=> low_port_latch == 8'hFF)
    else $error("low latch not all ones");
  a_high_kept: assert property (ale && !high_latch_we |=> $stable(high_port_latch))
    else $error("high latch changed by bus cycle");
  a_read_float: assert property (rd_low |-> data_oe == 8'h00)
    else $error("data port driven during read");
  a_prog_pick: assert property (!program_read_strobe_b |-> fetch
    || (req.kind == KIND_READ && strobe_config_field[0])) else $error("bad program strobe");
  a_data_pick: assert property (!data_read_strobe_b |-> req.kind == KIND_READ
    && !strobe_config_field[0]) else $error("bad data read strobe");
  a_write_steady: assert property (!write_strobe_b |-> data_oe == 8'hFF ##1
    (write_strobe_b || ($stable(low_port) && $stable(high_port)))) else $error("write data moved");
  a_wait_stretch: assert property (s_start_w3 |-> s_held4)
    else $error("strobe not stretched by wait states");
endmodule
bind ext_bus_port ext_bus_sva #(.W(W)) u_sva (
  .clk(clk), .rst_b(rst_b), .page_mode(page_mode), .high_latch_we(high_latch_we),
  .strobe_config_field(strobe_config_field), .wait_states(wait_states),
  .low_port_latch(low_port_latch), .high_port_latch(high_port_latch), .req(req),
  .low_port(low_port), .high_port(high_port), .addr_latch_strobe(addr_latch_strobe),
  .program_read_strobe_b(program_read_strobe_b), .data_read_strobe_b(data_read_strobe_b),
  .write_strobe_b(write_strobe_b), .addr16_out(addr16_out), .addr16_oe(addr16_oe));
`default_nettype wire

/* File: ext_mem_model.sv */
// external memory with address latch, answering on the two bus ports
// assumes registered strobes from the port block, one clock
`default_nettype none
module ext_mem_model
  import ext_bus_pkg::*;
(
  // bus side
  input wire logic         clk, page_mode, slow,
  input wire logic         addr_latch_strobe, program_read_strobe_b, data_read_strobe_b,
  input wire logic         write_strobe_b,
  input wire port_drive_t  low_port, high_port,
  // pin levels and what the memory saw
  output logic [7:0]       low_lvl, high_lvl, wdat,
  output logic [15:0]      maddr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] prev = 8'h00;
  logic       drv  = 1'b0;
  logic       rd;
  logic [7:0] d;
  assign rd = !(program_read_strobe_b && data_read_strobe_b);
  assign d = maddr[15:8] ^ maddr[7:0] ^ 8'h5A;
  ////////////////////////////////////////////////////////////////////////////////
  // slow part answers late in the strobe, still before release
  always @(rd) drv <= #(slow ? 20 : 1) rd;
  // released low pins float (no pullups): inverse of last level; high pins pull up
  assign low_lvl = (low_port.out & low_port.oe) | (~low_port.oe & (drv && !page_mode ? d : ~prev));
  assign high_lvl = (high_port.out & high_port.oe) | (~high_port.oe & (drv && page_mode ? d : 8'hFF));
  always @(posedge clk) prev <= low_lvl;
  always @(posedge clk) if (addr_latch_strobe) maddr <= {high_lvl, low_lvl};
  always @(posedge clk) if (!write_strobe_b) wdat <= page_mode ? high_lvl : low_lvl;
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the external bus port with a memory model
// assumes one 40 MHz clock; notes queued by the driver, checked at req_done
`default_nettype none
module tb_top
  import ext_bus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {bus_kind_t k; logic [7:0] d; logic [15:0] a;} note_t;
  logic        clk = 0, rst_b = 0, page_mode = 0, slow = 0, req_valid = 0;
  logic        low_latch_we = 0, high_latch_we = 0, req_done, ale, prs_b, drs_b, wr_b;
  strobe_cfg_t cfg = RS_DATA;
  logic [1:0]  ws = 2'h0;
  logic [7:0]  latch_wdata = 8'h00, lo_l, hi_l, rdata, lo_in, hi_in, wdat;
  logic [15:0] maddr;
  logic [16:0] lfsr = 17'h1694F;
  bus_req_t    req = '0;
  port_drive_t low_port, high_port;
  note_t       notes[$];
  note_t       m;
  int          failures = 0, check_count = 0;
  ext_bus_port #(.W(2)) uut (
    .clk(clk), .rst_b(rst_b), .page_mode(page_mode), .strobe_config_field(cfg),
    .wait_states(ws), .low_latch_we(low_latch_we), .high_latch_we(high_latch_we),
    .latch_wdata(latch_wdata), .low_port_latch(lo_l), .high_port_latch(hi_l),
    .req_valid(req_valid), .req(req), .req_done(req_done), .rdata(rdata),
    .low_port_in(lo_in), .high_port_in(hi_in), .low_port(low_port), .high_port(high_port),
    .addr_latch_strobe(ale), .program_read_strobe_b(prs_b), .data_read_strobe_b(drs_b),
    .write_strobe_b(wr_b), .addr16_out(), .addr16_oe());
  ext_mem_model mem (
    .clk(clk), .page_mode(page_mode), .slow(slow), .addr_latch_strobe(ale),
    .program_read_strobe_b(prs_b), .data_read_strobe_b(drs_b), .write_strobe_b(wr_b),
    .low_port(low_port), .high_port(high_port), .low_lvl(lo_in), .high_lvl(hi_in),
    .wdat(wdat), .maddr(maddr));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [16:0] step(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // kind, form, mode, waits, strobe choice and answer speed all walk with i
  task automatic xfer(input int i);
    bus_req_t r;
    note_t    n;
    int       t;
    r = '{kind: bus_kind_t'(i % 3), form: insn_form_t'((i / 3) % 3), ext_mode: i[2],
          addr: lfsr, wdata: lfsr[16:9]};
    n.k = r.kind;
    n.a = (r.form == FORM_BYTE_REG && r.kind != KIND_FETCH) ? {8'hA5, r.addr[7:0]} : r.addr[15:0];
    n.d = (r.kind == KIND_WRITE) ? r.wdata : n.a[15:8] ^ n.a[7:0] ^ 8'h5A;
    notes.push_back(n);
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    page_mode <= i[0];
    ws <= i[3:2];
    cfg <= strobe_cfg_t'(i[1:0]);
    slow <= i[1];
    // taken at the next edge from idle; a level still high at req_done restarts
    @(posedge clk);
    req_valid <= 1'b0;
    t = 0;
    do @(posedge clk); while (req_done !== 1'b1 && ++t < 100);
    if (t >= 100) failures++;
    lfsr = step(lfsr);
  endtask
  initial forever #12.5 clk = ~clk;
  always @(negedge clk) if (req_done === 1'b1) begin
    m = notes.size() ? notes.pop_front() : '{KIND_WRITE, 8'h00, 16'hDEAD};
    cmp("address", m.a, maddr);
    if (m.k == KIND_WRITE) cmp("write data", m.d, wdat);
    else cmp("read data", m.d, rdata);
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    low_latch_we <= 1'b1;
    latch_wdata <= 8'h3C;
    @(posedge clk);
    low_latch_we <= 1'b0;
    high_latch_we <= 1'b1;
    latch_wdata <= 8'hA5;
    @(posedge clk);
    high_latch_we <= 1'b0;
    // pins follow the latch one edge later
    @(posedge clk);
    @(negedge clk);
    cmp("low latch", 8'h3C, lo_l);
    cmp("idle high pins", 8'hA5, high_port.out);
    for (int i = 0; i < 24; i++) xfer(i);
    @(negedge clk);
    cmp("low latch", 8'hFF, lo_l);
    cmp("high latch", 8'hA5, hi_l);
    cmp("idle high pins", 8'hA5, high_port.out);
    cmp("notes left", 16'h0000, 16'(notes.size()));
    summarize();
  end
  // 24 transfers of at most 12 cycles each; this span leaves a wide margin
  initial begin
    #125000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire

/* File: wait_stretch.sv */
// counts one phase of a bus cycle, lengthened by configured wait states
// assumes start is a one-cycle pulse and no restart while busy
`default_nettype none
module wait_stretch
  import ext_bus_pkg::*;
#(
  parameter int W = WAIT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // control
  input  wire logic         start,
  input  wire logic [W-1:0] waits,
  input  wire logic [1:0]   base,
  output logic              done
);

  logic [W+1:0] count;
  logic         busy;

  assign done = busy && (count == '0);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (start) begin
      count <= (W+2)'(base) + (W+2)'(waits) - (W+2)'(1);
      busy  <= 1'b1;
    end else if (busy) begin
      if (count == '0)
        busy <= 1'b0;
      else
        count <= count - (W+2)'(1);
    end
  end

endmodule
`default_nettype wire
